// ==== common/frame_map.vh ====
`ifndef FRAME_MAP_VH
`define FRAME_MAP_VH

////////////////////////////////////////////////////////////////
// host frame bytes and configuration byte fields
`define START_BYTE      8'h55
`define CFG_CONFIG_BIT  7
`define CFG_EXT_BIT     6
`define CFG_ECHO_BIT    5
`define CFG_TCLR_BIT    4
`define SEL_RATE        4'h1
`define SEL_FILTER      4'h2
`define SEL_PRESET      4'h3
`define SEL_STAMP_OFF   4'h4
`define SEL_PIN         4'h5
`define SEL_BINARY      4'h6
`define SEL_ASCII       4'h7

////////////////////////////////////////////////////////////////
// payload lengths in bytes and the standard id limit
`define LEN_RATE        5'h01
`define LEN_FILTER      5'h10
`define LEN_PRESET      5'h02
`define LEN_PIN         5'h04
`define LEN_CAN_HEAD    5'h05
`define DLC_MAX         4'h8
`define STD_ID_MAX      32'h000007ff

////////////////////////////////////////////////////////////////
// bit-rate table, kbit/s
`define RATE_1          11'h014
`define RATE_2          11'h032
`define RATE_3          11'h064
`define RATE_4          11'h07d
`define RATE_5          11'h0fa
`define RATE_6          11'h1f4
`define RATE_7          11'h3e8

////////////////////////////////////////////////////////////////
// timestamp timer
`define CLK_PERIOD_NS   20
`define STAMP_TICK_NS   1000000
`define STAMP_WRAP      16'hea5f

////////////////////////////////////////////////////////////////
// receive modes
`define RXM_ALL_FILT    2'h0
`define RXM_STD_ONLY    2'h1
`define RXM_EXT_ONLY    2'h2
`define RXM_ANY         2'h3

////////////////////////////////////////////////////////////////
// apb register byte offsets and fields
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_STAMP       8'h08
`define REG_SLOT_CTRL   8'h0c
`define REG_SLOT_ID     8'h10
`define REG_SLOT_DLC    8'h14
`define REG_SLOT_DHI    8'h18
`define REG_SLOT_DLO    8'h1c
`define SLOT_SEL_BIT    0
`define SLOT_REL_BIT    1
`define SLOT_W          99

`endif

// ==== hdl/slot_store.v ====
`include "frame_map.vh"

// two receive slots, registered read port
module slot_store (
	// clock, no reset
	input  wire                 clk,
	// write port
	input  wire                 wr_en,
	input  wire                 wr_addr,
	input  wire [`SLOT_W-1:0]   wr_data,
	// read port
	input  wire                 rd_addr,
	output reg  [`SLOT_W-1:0]   rd_data
);

	reg [`SLOT_W-1:0] mem_reg [0:1];

	always @(posedge clk) begin
		if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
		rd_data <= mem_reg[rd_addr];
	end

endmodule

// ==== hdl/frame_decoder.v ====
// Contract
// RL1: every frame starts with byte 0x55
// RL2: second byte is the configuration byte
// RL3: bit 7 picks configuration or CAN payload
// RL4: CAN frame: id4, length, 1-8 data, checksum
// RL5: format, echo, timer-clear only in CAN frames
// RL6: bit 6 extended; long id forces extended
// RL7: bit 5 echoes the host message back
// RL8: bit 4 clears and starts 16-bit timer
// RL9: bits 3-0 pick the setting in config frames
// RL10: bit-rate command 0x81, one code byte
// RL11: codes 1-7 map 20k to 1M
// RL12: two receive slots, two masks, two filters
// RL13: assembly buffer always takes next message
// RL14: accepted message to slot 0, else slot 1
// RL15: mode 00: filters decide, enable picks format
// RL16: modes 01/10: standard or extended only
// RL17: mode 11: store all, errored ones too
// RL18: masked bits must equal filter bits
// RL19: filter command 0x82: 8 filter, 8 mask bytes
// RL20: host link runs at 115.2 kbit/s
// RL21: checksum is byte sum of prior bytes
// RL22: bad start, sum or selector drops frame
//
// Design decisions made here: the placing of the registers and the APB slave port.
`include "frame_map.vh"

module frame_decoder #(
	parameter TICK_CYCLES = `STAMP_TICK_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire         clk,
	input  wire         nrst,
	// apb slave
	input  wire         psel,
	input  wire         penable,
	input  wire         pwrite,
	input  wire [7:0]   paddr,
	input  wire [31:0]  pwdata,
	output reg  [31:0]  prdata,
	output reg          pready,
	output reg          pslverr,
	// host byte stream in; the 115.2 kbit/s line is decoded upstream [RL20]
	input  wire         host_valid,
	input  wire [7:0]   host_byte,
	// echo byte stream out, to the serial sender
	output reg          echo_valid,
	output reg  [7:0]   echo_byte,
	// message to the can bus
	output reg          can_tx_valid,
	output reg  [28:0]  can_tx_id,
	output reg          can_tx_ext,
	output reg  [3:0]   can_tx_dlc,
	output reg  [63:0]  can_tx_data,
	// message from the can bus
	input  wire         bus_msg_valid,
	input  wire         bus_msg_err,
	input  wire [28:0]  bus_msg_id,
	input  wire         bus_msg_ext,
	input  wire [3:0]   bus_msg_dlc,
	input  wire [63:0]  bus_msg_data,
	// settings
	output reg  [2:0]   rate_code,
	output reg  [10:0]  rate_kbps,
	output reg          ascii_mode,
	output reg          stamp_on,
	output reg  [15:0]  stamp_value,
	output reg  [31:0]  pin_code,
	output reg          pin_update
);

	localparam ST_IDLE = 4'b0001;
	localparam ST_CFG  = 4'b0010;
	localparam ST_BODY = 4'b0100;
	localparam ST_SUM  = 4'b1000;

	////////////////////////////////////////////////////////////////
	// host frame parser
	reg [3:0]   state_reg;
	reg [7:0]   cfg_reg;
	reg [7:0]   sum_reg;
	reg [4:0]   cnt_reg;
	reg [4:0]   len_reg;
	reg [127:0] pay_reg;
	reg         exec_reg;

	wire        is_cfg  = cfg_reg[`CFG_CONFIG_BIT];
	wire [4:0]  cnt_inc = cnt_reg + 5'h01;
	wire [4:0]  left_sh = 5'h10 - len_reg;
	// first payload byte lands in the top byte
	wire [127:0] aligned = pay_reg << {left_sh, 3'b000};

	always @(posedge clk) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			cfg_reg   <= 8'h00;
			sum_reg   <= 8'h00;
			cnt_reg   <= 5'h00;
			len_reg   <= 5'h00;
			pay_reg   <= 128'h0;
			exec_reg  <= 1'b0;
		end else begin
			exec_reg <= 1'b0;
			if (host_valid) begin
				case (state_reg)
				ST_IDLE: begin
					// anything but the start byte is skipped while hunting
					if (host_byte == `START_BYTE) begin // [RL1] [RL22]
						sum_reg   <= host_byte;
						state_reg <= ST_CFG;
					end
				end
				ST_CFG: begin
					cfg_reg <= host_byte; // [RL2]
					sum_reg <= sum_reg + host_byte;
					cnt_reg <= 5'h00;
					pay_reg <= 128'h0;
					if (host_byte[`CFG_CONFIG_BIT]) begin // [RL3]
						case (host_byte[3:0]) // [RL9]
						`SEL_RATE: begin // [RL10]
							len_reg   <= `LEN_RATE;
							state_reg <= ST_BODY;
						end
						`SEL_FILTER: begin // [RL19]
							len_reg   <= `LEN_FILTER;
							state_reg <= ST_BODY;
						end
						`SEL_PRESET: begin
							len_reg   <= `LEN_PRESET;
							state_reg <= ST_BODY;
						end
						`SEL_PIN: begin
							len_reg   <= `LEN_PIN;
							state_reg <= ST_BODY;
						end
						`SEL_STAMP_OFF, `SEL_BINARY, `SEL_ASCII: begin
							len_reg   <= 5'h00;
							state_reg <= ST_SUM;
						end
						default: begin
							state_reg <= ST_IDLE; // [RL22]
						end
						endcase
					end else begin
						len_reg   <= `LEN_CAN_HEAD; // [RL4]
						state_reg <= ST_BODY;
					end
				end
				ST_BODY: begin
					pay_reg <= {pay_reg[119:0], host_byte};
					sum_reg <= sum_reg + host_byte;
					cnt_reg <= cnt_inc;
					if (!is_cfg && cnt_reg == 5'h04) begin
						// length byte: only 1..8 data bytes are legal
						if (host_byte[7:4] != 4'h0 || host_byte[3:0] == 4'h0 ||
								host_byte[3:0] > `DLC_MAX) begin // [RL4]
							state_reg <= ST_IDLE;
						end else begin
							len_reg <= `LEN_CAN_HEAD + {1'b0, host_byte[3:0]};
						end
					end else if (cnt_inc == len_reg) begin
						state_reg <= ST_SUM;
					end
				end
				ST_SUM: begin
					exec_reg  <= (host_byte == sum_reg); // [RL21] [RL22]
					sum_reg   <= host_byte;
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// frame execution
	reg  [31:0] filt_reg [0:3];
	reg  [15:0] tick_reg;
	wire        can_frame = exec_reg && !is_cfg;
	wire        cfg_frame = exec_reg && is_cfg;
	wire [31:0] raw_id    = aligned[127:96];
	wire        long_id   = raw_id > `STD_ID_MAX;

	always @(posedge clk) begin
		if (!nrst) begin
			can_tx_valid <= 1'b0;
			can_tx_id    <= 29'h0;
			can_tx_ext   <= 1'b0;
			can_tx_dlc   <= 4'h0;
			can_tx_data  <= 64'h0;
			rate_code    <= 3'h0;
			rate_kbps    <= 11'h0;
			ascii_mode   <= 1'b0;
			stamp_on     <= 1'b0;
			stamp_value  <= 16'h0;
			tick_reg     <= 16'h0;
			pin_code     <= 32'h0;
			pin_update   <= 1'b0;
			filt_reg[0]  <= 32'h0;
			filt_reg[1]  <= 32'h0;
			filt_reg[2]  <= 32'h0;
			filt_reg[3]  <= 32'h0;
		end else begin
			can_tx_valid <= can_frame; // [RL3]
			pin_update   <= 1'b0;
			if (stamp_on) begin
				if (tick_reg == TICK_CYCLES - 1) begin
					tick_reg    <= 16'h0;
					stamp_value <= (stamp_value == `STAMP_WRAP) ? 16'h0 :
						stamp_value + 16'h0001;
				end else begin
					tick_reg <= tick_reg + 16'h0001;
				end
			end
			if (can_frame) begin
				can_tx_id   <= raw_id[28:0];
				can_tx_ext  <= cfg_reg[`CFG_EXT_BIT] | long_id; // [RL5] [RL6]
				can_tx_dlc  <= aligned[91:88];
				can_tx_data <= aligned[87:24];
				if (cfg_reg[`CFG_TCLR_BIT]) begin // [RL5] [RL8]
					stamp_value <= 16'h0;
					tick_reg    <= 16'h0;
					stamp_on    <= 1'b1;
				end
			end
			// format, echo and timer-clear bits are not looked at here
			if (cfg_frame) begin // [RL5]
				case (cfg_reg[3:0]) // [RL9]
				`SEL_RATE: begin
					// unknown code keeps the old rate
					case (aligned[127:120]) // [RL11]
					8'h01: rate_kbps <= `RATE_1;
					8'h02: rate_kbps <= `RATE_2;
					8'h03: rate_kbps <= `RATE_3;
					8'h04: rate_kbps <= `RATE_4;
					8'h05: rate_kbps <= `RATE_5;
					8'h06: rate_kbps <= `RATE_6;
					8'h07: rate_kbps <= `RATE_7;
					default: rate_kbps <= rate_kbps;
					endcase
					if (aligned[127:120] != 8'h00 && aligned[127:123] == 5'h00) begin
						rate_code <= aligned[122:120]; // [RL10]
					end
				end
				`SEL_FILTER: begin // [RL19]
					filt_reg[0] <= aligned[127:96];
					filt_reg[1] <= aligned[95:64];
					filt_reg[2] <= aligned[63:32];
					filt_reg[3] <= aligned[31:0];
				end
				`SEL_PRESET: begin
					stamp_value <= aligned[127:112];
					tick_reg    <= 16'h0;
					stamp_on    <= 1'b1;
				end
				`SEL_STAMP_OFF: stamp_on <= 1'b0;
				`SEL_PIN: begin
					pin_code   <= aligned[127:96];
					pin_update <= 1'b1;
				end
				`SEL_BINARY: ascii_mode <= 1'b0;
				`SEL_ASCII: ascii_mode <= 1'b1;
				default: ascii_mode <= ascii_mode;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// echo: replays a checked CAN frame byte by byte
	reg [143:0] echo_sr_reg;
	reg [4:0]   echo_left_reg;
	reg [7:0]   echo_sum_reg;

	always @(posedge clk) begin
		if (!nrst) begin
			echo_sr_reg   <= 144'h0;
			echo_left_reg <= 5'h00;
			echo_sum_reg  <= 8'h00;
			echo_valid    <= 1'b0;
			echo_byte     <= 8'h00;
		end else begin
			echo_valid <= 1'b0;
			if (can_frame && cfg_reg[`CFG_ECHO_BIT]) begin // [RL5] [RL7]
				echo_sr_reg   <= {`START_BYTE, cfg_reg, aligned};
				echo_left_reg <= len_reg + 5'h03;
				echo_sum_reg  <= sum_reg;
			end else if (echo_left_reg != 5'h00) begin // [RL7]
				echo_valid    <= 1'b1;
				echo_byte     <= (echo_left_reg == 5'h01) ? echo_sum_reg :
					echo_sr_reg[143:136];
				echo_sr_reg   <= {echo_sr_reg[135:0], 8'h00};
				echo_left_reg <= echo_left_reg - 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// assembly buffer and acceptance
	reg         asm_valid_reg;
	reg         asm_err_reg;
	reg [28:0]  asm_id_reg;
	reg         asm_ext_reg;
	reg [3:0]   asm_dlc_reg;
	reg [63:0]  asm_data_reg;
	reg [1:0]   rxm_reg;
	reg [1:0]   slot_full_reg;
	reg         slot_sel_reg;
	wire [1:0]  hit;
	wire [`SLOT_W-1:0] slot_rd;

	// no back-pressure: a new message simply replaces the old one
	always @(posedge clk) begin
		if (!nrst) begin
			asm_valid_reg <= 1'b0;
			asm_err_reg   <= 1'b0;
			asm_id_reg    <= 29'h0;
			asm_ext_reg   <= 1'b0;
			asm_dlc_reg   <= 4'h0;
			asm_data_reg  <= 64'h0;
		end else begin
			asm_valid_reg <= bus_msg_valid; // [RL13]
			if (bus_msg_valid) begin
				asm_err_reg  <= bus_msg_err;
				asm_id_reg   <= bus_msg_id;
				asm_ext_reg  <= bus_msg_ext;
				asm_dlc_reg  <= bus_msg_dlc;
				asm_data_reg <= bus_msg_data;
			end
		end
	end

	// standard ids sit in the top 11 bits of the 29-bit key
	wire [28:0] msg_key = asm_ext_reg ? asm_id_reg : {asm_id_reg[10:0], 18'h0};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : accept
			wire [31:0] f  = filt_reg[gi];
			wire [31:0] m  = filt_reg[gi + 2];
			wire [28:0] fk = {f[23:16], f[31:29], f[25:24], f[7:0], f[15:8]};
			wire [28:0] mk = {m[23:16], m[31:29], m[25:24], m[7:0], m[15:8]};
			wire [28:0] mu = asm_ext_reg ? mk : {mk[28:18], 18'h0};
			wire        extended_id_enable = f[27];
			wire        fmt_ok = (rxm_reg == `RXM_ALL_FILT) ? (extended_id_enable == asm_ext_reg) :
				(rxm_reg == `RXM_STD_ONLY) ? (!extended_id_enable && !asm_ext_reg) :
				(extended_id_enable && asm_ext_reg); // [RL15] [RL16]
			assign hit[gi] = fmt_ok && (((msg_key ^ fk) & mu) == 29'h0); // [RL18] [RL12]
		end
	endgenerate

	wire take_any = (rxm_reg == `RXM_ANY); // [RL17]
	wire accepted = asm_valid_reg && (take_any || (!asm_err_reg && (hit != 2'b00)));
	wire to_slot0 = !slot_full_reg[0]; // [RL14]
	wire store_en = accepted && (slot_full_reg != 2'b11);

	slot_store u_slots (
		.clk     (clk),
		.wr_en   (store_en),
		.wr_addr (!to_slot0),
		.wr_data ({asm_err_reg, asm_ext_reg, asm_id_reg, asm_dlc_reg, asm_data_reg}),
		.rd_addr (slot_sel_reg),
		.rd_data (slot_rd)
	);

	////////////////////////////////////////////////////////////////
	// apb slave
	wire setup   = psel && !penable;
	wire wr_take = psel && penable && pready && pwrite;
	wire release_hit = wr_take && (paddr == `REG_SLOT_CTRL) && pwdata[`SLOT_REL_BIT];
	reg  [31:0] rd_mux;
	reg         rd_ok;

	always @* begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0;
		case (paddr)
		`REG_CTRL:      rd_mux = {30'h0, rxm_reg};
		`REG_STATUS:    rd_mux = {25'h0, rate_code, ascii_mode, stamp_on, slot_full_reg};
		`REG_STAMP:     rd_mux = {16'h0, stamp_value};
		`REG_SLOT_CTRL: rd_mux = {31'h0, slot_sel_reg};
		`REG_SLOT_ID:   rd_mux = {1'b0, slot_rd[98:68]};
		`REG_SLOT_DLC:  rd_mux = {28'h0, slot_rd[67:64]};
		`REG_SLOT_DHI:  rd_mux = slot_rd[63:32];
		`REG_SLOT_DLO:  rd_mux = slot_rd[31:0];
		default:        rd_ok  = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (!nrst) begin
			pready        <= 1'b0;
			prdata        <= 32'h0;
			pslverr       <= 1'b0;
			rxm_reg       <= `RXM_ALL_FILT;
			slot_sel_reg  <= 1'b0;
			slot_full_reg <= 2'b00;
		end else begin
			// answer is prepared in setup so access ends at its first edge
			pready  <= setup;
			pslverr <= setup && !rd_ok;
			prdata  <= (setup && !pwrite) ? rd_mux : 32'h0;
			if (wr_take && paddr == `REG_CTRL) begin
				rxm_reg <= pwdata[1:0];
			end
			if (wr_take && paddr == `REG_SLOT_CTRL) begin
				slot_sel_reg <= pwdata[`SLOT_SEL_BIT];
			end
			// a store in the release cycle still sees the slot full, so it goes to the other slot or is dropped
			slot_full_reg[0] <= (store_en && to_slot0) ||
				(slot_full_reg[0] && !(release_hit && !slot_sel_reg)); // [RL14]
			slot_full_reg[1] <= (store_en && !to_slot0) ||
				(slot_full_reg[1] && !(release_hit && slot_sel_reg)); // [RL14]
		end
	end

endmodule

// ==== verification/frame_checker.sv ====
`include "frame_map.vh"
module frame_checker (
	// clock and reset
	input logic        clk,
	input logic        nrst,
	// register bus
	input logic        psel,
	input logic        penable,
	input logic        pready,
	input logic        pslverr,
	// streams and settings
	input logic        echo_valid,
	input logic [7:0]  echo_byte,
	input logic        can_tx_valid,
	input logic [28:0] can_tx_id,
	input logic        can_tx_ext,
	input logic [3:0]  can_tx_dlc,
	input logic [2:0]  rate_code,
	input logic [10:0] rate_kbps,
	input logic [15:0] stamp_value
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence apb_done;
		psel && penable && pready;
	endsequence
	////////////////////////////////////////
	ready_next_a: assert property (apb_setup |=> apb_done)
		else $error("no ready after setup");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	tx_pulse_a: assert property (can_tx_valid |=> !can_tx_valid)
		else $error("send pulse too long");
	long_id_a: assert property (can_tx_valid && can_tx_id > 29'h7ff |-> can_tx_ext)
		else $error("long id sent as standard");
	dlc_range_a: assert property (can_tx_valid |-> can_tx_dlc inside {[1:8]})
		else $error("length out of range");
	rate_low_a: assert property (rate_code == 3'h1 |-> rate_kbps == `RATE_1)
		else $error("lowest rate wrong");
	rate_top_a: assert property (rate_code == 3'h7 |-> rate_kbps == `RATE_7)
		else $error("top rate wrong");
	// shortest echoed frame is nine bytes long
	echo_burst_a: assert property ($rose(echo_valid) |-> echo_byte == 8'h55 ##0 echo_valid[*8])
		else $error("echo burst malformed");
	stamp_wrap_a: assert property (stamp_value <= `STAMP_WRAP)
		else $error("timer past wrap");
endmodule

bind frame_decoder frame_checker i_frame_checker (
	.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .echo_valid(echo_valid), .echo_byte(echo_byte),
	.can_tx_valid(can_tx_valid), .can_tx_id(can_tx_id), .can_tx_ext(can_tx_ext),
	.can_tx_dlc(can_tx_dlc), .rate_code(rate_code), .rate_kbps(rate_kbps),
	.stamp_value(stamp_value)
);

// ==== verification/host_link.sv ====
module host_link (
	// clock
	input  logic       clk,
	// byte stream
	output logic       host_valid,
	output logic [7:0] host_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] q[$];
	logic [7:0] sent[$];
	logic [7:0] sum;
	initial begin
		host_valid = 1'b0;
		host_byte = 8'h00;
	end
	// frame in q starts with the start byte; bad flips checksum bit 0
	task automatic send(input int gap, input logic bad);
		sum = 8'h00;
		foreach (q[i]) sum += q[i];
		q.push_back(sum ^ {7'h00, bad});
		sent = q;
		foreach (q[i]) begin
			host_valid <= 1'b1;
			host_byte  <= q[i];
			@(posedge clk);
			repeat (gap) begin
				host_valid <= 1'b0;
				host_byte  <= ~q[i];
				@(posedge clk);
			end
		end
		// idle line shows its last value inverted, so after a gap it shows the last byte again
		host_valid <= 1'b0;
		host_byte  <= ~host_byte;
		q.delete();
	endtask
endmodule

// ==== verification/tb.sv ====
`include "frame_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr, host_byte, echo_byte;
	logic [31:0] pwdata, prdata, pin_code, rd;
	logic        host_valid, echo_valid, tx_v, tx_ext, ascii_mode, stamp_on, pin_upd;
	logic        msg_v, msg_err, msg_ext;
	logic [28:0] msg_id, tx_id;
	logic [3:0]  tx_dlc;
	logic [63:0] tx_data;
	logic [2:0]  rate_code;
	logic [10:0] rate_kbps;
	logic [15:0] stamp_value;
	logic [7:0]  eq[$];
	logic [10:0] kb[1:7] = '{`RATE_1, `RATE_2, `RATE_3, `RATE_4, `RATE_5, `RATE_6, `RATE_7};
	logic [23:0] bad_f[5] = '{24'h548102, 24'h558102, 24'h558802, 24'h558002, 24'h558100};
	int          fail_count = 0;
	int          comparisons = 0;
	int          tx_cnt = 0;
	int          pin_cnt = 0;

	frame_decoder #(.TICK_CYCLES(4)) i_frame_decoder (
		.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .host_valid(host_valid), .host_byte(host_byte),
		.echo_valid(echo_valid), .echo_byte(echo_byte), .can_tx_valid(tx_v),
		.can_tx_id(tx_id), .can_tx_ext(tx_ext), .can_tx_dlc(tx_dlc),
		.can_tx_data(tx_data), .bus_msg_valid(msg_v), .bus_msg_err(msg_err),
		.bus_msg_id(msg_id), .bus_msg_ext(msg_ext), .bus_msg_dlc(msg_id[3:0]),
		.bus_msg_data({msg_id, 6'h0, msg_id}), .rate_code(rate_code), .rate_kbps(rate_kbps),
		.ascii_mode(ascii_mode), .stamp_on(stamp_on), .stamp_value(stamp_value),
		.pin_code(pin_code), .pin_update(pin_upd)
	);
	host_link i_host_link (.clk(clk), .host_valid(host_valid), .host_byte(host_byte));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (tx_v === 1'b1)
			tx_cnt++;
		if (echo_valid === 1'b1)
			eq.push_back(echo_byte);
		if (pin_upd === 1'b1)
			pin_cnt++;
	end
	////////////////////////////////////////
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask
	// automatic; only the main sequence calls it, the watchdog waits with its own repeat loop
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task final_report;
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fail_count++;
			final_report();
		end
		cyc(1);
	endtask
	task st(input logic [1:0] exp);
		apb(1'b0, `REG_STATUS, 32'h0);
		chk(rd[1:0], exp);
	endtask
	// four edges after the checksum so the pulse monitor has run
	task put(input logic [7:0] b[$], input int gap, input logic bad);
		i_host_link.q = b;
		i_host_link.send(gap, bad);
		cyc(4);
	endtask
	task rx(input logic [28:0] id, input logic ext, input logic err, input int n);
		msg_v   <= 1'b1;
		msg_id  <= id;
		msg_ext <= ext;
		msg_err <= err;
		@(posedge clk);
		if (n > 0) begin
			msg_v <= 1'b0;
			// idle message lines show junk, only valid qualifies them
			msg_id <= ~id;
			cyc(n);
		end
	endtask
	task can(input logic [7:0] cfg, input logic [31:0] id, input int n, input logic ext);
		logic [7:0]  b[$];
		logic [63:0] d;
		int          t;
		b = {8'h55, cfg, id[31:24], id[23:16], id[15:8], id[7:0], 8'(n)};
		d = '0;
		t = tx_cnt;
		for (int i = 0; i < n; i++) begin
			b.push_back(8'(17 * (i + 1)));
			d[63 - 8 * i -: 8] = 8'(17 * (i + 1));
		end
		eq.delete();
		put(b, 0, 1'b0);
		chk(tx_cnt, t + 1);
		chk({tx_id, tx_ext, tx_dlc}, {id[28:0], ext, n[3:0]});
		chk(tx_data, d);
		if (cfg[4])
			chk({stamp_on, stamp_value <= 16'h0001}, 2'h3);
		cyc(20);
		chk(eq.size(), cfg[5] ? i_host_link.sent.size() : 0);
		foreach (eq[i]) chk(eq[i], i_host_link.sent[i]);
	endtask
	////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{msg_v, msg_err, msg_ext, msg_id} = '0;
		nrst = 1'b0;
		cyc(8);
		nrst <= 1'b1;
		st(2'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		$display("test registers done");
		for (int c = 1; c <= 7; c++) begin
			put({8'h55, 8'h81, 8'(c)}, c % 3, 1'b0);
			chk({rate_code, rate_kbps}, {3'(c), kb[c]});
		end
		foreach (bad_f[i]) begin
			put({bad_f[i][23:16], bad_f[i][15:8], bad_f[i][7:0]}, 0, i == 1);
			chk(rate_code, 3'h7);
		end
		put({8'h55, 8'h81, 8'h03}, 0, 1'b0);
		chk(rate_code, 3'h3);
		apb(1'b0, `REG_STATUS, 32'h0);
		chk(rd[6:4], 3'h3);
		$display("test rates done");
		eq.delete();
		put({8'h55, 8'ha7}, 0, 1'b0);
		cyc(4);
		chk({ascii_mode, eq.size() == 0}, 2'h3);
		put({8'h55, 8'h86}, 0, 1'b0);
		chk(ascii_mode, 1'b0);
		put({8'h55, 8'h83, 8'h12, 8'h34}, 0, 1'b0);
		chk(stamp_value inside {16'h1234, 16'h1235}, 1'b1);
		apb(1'b0, `REG_STAMP, 32'h0);
		chk(rd inside {32'h1234, 32'h1235}, 1'b1);
		put({8'h55, 8'h84}, 0, 1'b0);
		chk(stamp_on, 1'b0);
		put({8'h55, 8'h85, 8'h31, 8'h32, 8'h33, 8'h34}, 0, 1'b0);
		chk(pin_code, 32'h31323334);
		chk(pin_cnt, 32'h1);
		$display("test settings done");
		can(8'h30, 32'h123, 8, 1'b0);
		can(8'h40, 32'h123, 1, 1'b1);
		can(8'h00, 32'h800, 1, 1'b1);
		$display("test can frames done");
		put({8'h55, 8'h82, 8'h60, 8'h24, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00,
			8'hc0, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff}, 0, 1'b0);
		rx(29'h123, 1'b0, 1'b0, 3);
		st(2'h1);
		rx(29'h124, 1'b0, 1'b0, 3);
		st(2'h1);
		rx(29'h122, 1'b0, 1'b0, 3);
		st(2'h3);
		apb(1'b1, `REG_SLOT_CTRL, 32'h1);
		apb(1'b0, `REG_SLOT_ID, 32'h0);
		chk(rd, 32'h122);
		apb(1'b1, `REG_SLOT_CTRL, 32'h3);
		apb(1'b1, `REG_SLOT_CTRL, 32'h0);
		apb(1'b1, `REG_SLOT_CTRL, 32'h2);
		apb(1'b1, `REG_CTRL, 32'h1);
		rx(29'h0, 1'b1, 1'b0, 3);
		st(2'h0);
		apb(1'b1, `REG_CTRL, 32'h2);
		rx(29'h123, 1'b0, 1'b0, 3);
		st(2'h0);
		apb(1'b1, `REG_CTRL, 32'h0);
		rx(29'h0, 1'b1, 1'b0, 3);
		st(2'h1);
		apb(1'b1, `REG_SLOT_CTRL, 32'h2);
		apb(1'b1, `REG_CTRL, 32'h3);
		rx(29'h1fffffff, 1'b1, 1'b1, 0);
		rx(29'h5, 1'b0, 1'b0, 3);
		st(2'h3);
		apb(1'b1, `REG_SLOT_CTRL, 32'h0);
		apb(1'b0, `REG_SLOT_ID, 32'h0);
		chk(rd, 32'h7fffffff);
		apb(1'b0, `REG_SLOT_DLC, 32'h0);
		chk(rd, 32'hf);
		apb(1'b0, `REG_SLOT_DHI, 32'h0);
		chk(rd, 32'hfffffff8);
		apb(1'b0, `REG_SLOT_DLO, 32'h0);
		chk(rd, 32'h1fffffff);
		apb(1'b0, `REG_CTRL, 32'h0);
		chk(rd, 32'h3);
		$display("test receive done");
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		final_report();
	end
endmodule
